// ### core/gdsr_pkg.sv
// package: constants and types for the gauge device status report block
package gdsr_pkg;
	localparam int          STAT_W         = 16;
	localparam int          SEL_W          = 4;
	localparam int          NUM_GAUGES     = 2;
	// bit positions of the device status word
	localparam int          BIT_HEADING    = 14;
	localparam int          BIT_ZERO_SIDE  = 12;
	localparam int          BIT_MISMATCH   = 10;
	localparam int          BIT_SUP_HIGH   = 9;
	localparam int          BIT_SUP_LOW    = 8;
	localparam int          BIT_CAL        = 7;
	localparam int          BIT_FAULT_ANY  = 6;
	localparam int          BIT_MOVED      = 4;
	localparam int          BIT_HOMING     = 2;
	localparam int          BIT_THERMAL    = 0;
	localparam int          SEL_TYPE_BIT   = 3;
	localparam int          BITCNT_W       = 4;
	localparam logic [SEL_W-1:0]    SEL_RESET    = 4'h0;
	localparam logic [STAT_W-1:0]   WORD_RESET   = 16'h0000;
	localparam logic [BITCNT_W-1:0] BITCNT_RESET = 4'h0;
	typedef enum logic [2:0] {
		GDSR_IDLE  = 3'b001,
		GDSR_SHIFT = 3'b010,
		GDSR_CHECK = 3'b100
	} gdsr_frame_t;
endpackage

// ### core/gdsr_flags_if.sv
// interface: latched fault flags and the valid-message clear strobe
interface gdsr_flags_if;
	import gdsr_pkg::*;
	logic                  clear_on_read;
	logic                  msg_end;
	logic                  sup_high;
	logic                  sup_low;
	logic                  fault_any;
	logic [NUM_GAUGES-1:0] moved;
	logic [NUM_GAUGES-1:0] homing;
	logic [NUM_GAUGES-1:0] thermal;
	modport frame (output clear_on_read, output msg_end, input sup_high, input sup_low,
		input fault_any, input moved, input homing, input thermal);
	modport latch (input clear_on_read, input msg_end, output sup_high, output sup_low,
		output fault_any, output moved, output homing, output thermal);
endinterface

// ### core/gdsr_fault_latch.sv
// module: sticky fault and event flags of the device status word
module gdsr_fault_latch
	import gdsr_pkg::*;
(
	input  wire logic                  core_clk,        // core clock
	input  wire logic                  rst_n,           // sync reset, active low
	input  wire logic                  clk_en,          // freezes state when low
	input  wire logic                  sup_high_evt,    // supply above limit
	input  wire logic                  sup_low_evt,     // supply below limit
	input  wire logic [NUM_GAUGES-1:0] pos_step,        // pointer position changed
	input  wire logic [NUM_GAUGES-1:0] homing_start,    // homing commanded on
	input  wire logic [NUM_GAUGES-1:0] homing_stop,     // homing commanded off
	input  wire logic [NUM_GAUGES-1:0] zero_found,      // zero position detected
	input  wire logic [NUM_GAUGES-1:0] thermal_evt,     // junction over temperature
	input  wire logic [NUM_GAUGES-1:0] gauge_reenable,  // host re-enabled gauge
	gdsr_flags_if.latch                fl               // flags toward framing
);
	logic                  sup_high_r;
	logic                  sup_low_r;
	logic [NUM_GAUGES-1:0] zero_seen_r;

	// set wins over clear so an event in the clearing cycle survives
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sup_high_r <= 1'b0;
			sup_low_r  <= 1'b0;
		end else if (clk_en) begin
			sup_high_r <= sup_high_evt | (sup_high_r & ~fl.clear_on_read);
			sup_low_r  <= sup_low_evt | (sup_low_r & ~fl.clear_on_read);
		end
	end

	assign fl.sup_high  = sup_high_r;
	assign fl.sup_low   = sup_low_r;
	assign fl.fault_any = sup_high_r | sup_low_r;

	genvar g;
	generate
		for (g = 0; g < NUM_GAUGES; g++) begin : g_gauge
			logic moved_r;
			logic homing_r;
			logic thermal_r;
			always_ff @(posedge core_clk) begin
				if (!rst_n) begin
					moved_r   <= 1'b0;
					homing_r  <= 1'b0;
					thermal_r <= 1'b0;
					zero_seen_r[g] <= 1'b0;
				end else if (clk_en) begin
					moved_r <= pos_step[g] | (moved_r & ~fl.msg_end);
					// homing clears on the message after zero, or on command off
					if (homing_start[g]) begin
						homing_r       <= 1'b1;
						zero_seen_r[g] <= 1'b0;
					end else if (homing_stop[g] || (zero_seen_r[g] && fl.msg_end)) begin
						homing_r       <= 1'b0;
						zero_seen_r[g] <= 1'b0;
					end else if (zero_found[g] && homing_r) begin
						zero_seen_r[g] <= 1'b1;
					end
					// held until re-enable; a new trip in that cycle still wins
					thermal_r <= thermal_evt[g] | (thermal_r & ~gauge_reenable[g]);
				end
			end
			assign fl.moved[g]   = moved_r;
			assign fl.homing[g]  = homing_r;
			assign fl.thermal[g] = thermal_r;
		end
	endgenerate
endmodule

// ### core/gdsr_status_report.sv
// module: device status word assembly, select latch and serial output framing
// Behaviour
// - selected status type persists until a new select write or reset
// - device status is output when the select field top bit is zero
// - bits 15 and 14 give travel direction of gauge 1 and gauge 0
// - bits 13 and 12 give configured zero-end side per gauge
// - bits 11 and 10 are 0 at commanded target, else 1
// - bit 9 latches supply-high events since last communication
// - supply-high event switches off coil drivers of both gauges
// - bit 8 latches supply-low events; outputs stay enabled
// - bit 7 shows clock calibration out of tolerance
// - bit 6 shows any supply fault since last communication
// - bits 5 and 4 show pointer position changed since last valid message
// - bits 3 and 2 held while homing; clear after zero or command off
// - bits 1 and 0 set on thermal trip, gauge disabled until re-enabled
// - the status word is read-only; serial input cannot write it
// - on chip-select fall the word loads and shifts out MSB first
// - latched supply faults clear only after a valid message shifting them out
// - valid length is nonzero multiple of 16, checked on chip-select rise
module gdsr_status_report
	import gdsr_pkg::*;
(
	input  wire logic                  core_clk,        // core clock, 100 MHz
	input  wire logic                  rst_n,           // sync reset, active low
	input  wire logic                  clk_en,          // freezes state when low
	input  wire logic                  cs_n_pin,        // chip select pin, active low
	input  wire logic                  sclk_pin,        // serial clock pin
	input  wire logic                  si_pin,          // serial data in pin
	output logic                       so_out,          // serial data out
	output logic                       so_oe_n,         // so driven when low
	input  wire logic                  sel_wr,          // valid select write strobe
	input  wire logic [SEL_W-1:0]      sel_val,         // status select field value
	input  wire logic [STAT_W-1:0]     alt_status,      // word of other status types
	input  wire logic [NUM_GAUGES-1:0] heading,         // direction per gauge
	input  wire logic [NUM_GAUGES-1:0] zero_end_side,   // zero side per gauge
	input  wire logic [NUM_GAUGES-1:0] target_mismatch, // not at target per gauge
	input  wire logic                  cal_out_of_range,// clock calibration bad
	input  wire logic                  sup_high_evt,    // supply above limit
	input  wire logic                  sup_low_evt,     // supply below limit
	input  wire logic [NUM_GAUGES-1:0] pos_step,        // pointer position changed
	input  wire logic [NUM_GAUGES-1:0] homing_start,    // homing commanded on
	input  wire logic [NUM_GAUGES-1:0] homing_stop,     // homing commanded off
	input  wire logic [NUM_GAUGES-1:0] zero_found,      // zero detected
	input  wire logic [NUM_GAUGES-1:0] thermal_evt,     // over temperature
	input  wire logic [NUM_GAUGES-1:0] gauge_reenable,  // host re-enabled gauge
	output logic [NUM_GAUGES-1:0]      driver_off,      // coil drivers forced off
	output logic [SEL_W-1:0]           status_select_field, // active select
	output logic                       msg_valid        // pulse: valid message end
);
	gdsr_flags_if fl ();

	gdsr_fault_latch u_latch (
		.core_clk       (core_clk),
		.rst_n          (rst_n),
		.clk_en         (clk_en),
		.sup_high_evt   (sup_high_evt),
		.sup_low_evt    (sup_low_evt),
		.pos_step       (pos_step),
		.homing_start   (homing_start),
		.homing_stop    (homing_stop),
		.zero_found     (zero_found),
		.thermal_evt    (thermal_evt),
		.gauge_reenable (gauge_reenable),
		.fl             (fl)
	);

	// pin synchronisers: first stage is read only by the second
	logic [2:0] cs_s1_r, cs_s2_r;
	logic       cs_d_r, sclk_d_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cs_s1_r  <= 3'b001;
			cs_s2_r  <= 3'b001;
			cs_d_r   <= 1'b1;
			sclk_d_r <= 1'b0;
		end else if (clk_en) begin
			cs_s1_r  <= {si_pin, sclk_pin, cs_n_pin};
			cs_s2_r  <= cs_s1_r;
			cs_d_r   <= cs_s2_r[0];
			sclk_d_r <= cs_s2_r[1];
		end
	end
	logic cs_q, sclk_q, si_q, cs_fall, cs_rise, sclk_rise, sclk_fall;
	assign cs_q      = cs_s2_r[0];
	assign sclk_q    = cs_s2_r[1];
	assign si_q      = cs_s2_r[2];
	assign cs_fall   = cs_d_r & ~cs_q;
	assign cs_rise   = ~cs_d_r & cs_q;
	assign sclk_rise = ~sclk_d_r & sclk_q;
	assign sclk_fall = sclk_d_r & ~sclk_q;

	// select latch: only a valid write moves it
	logic [SEL_W-1:0] sel_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			sel_r <= SEL_RESET;
		else if (clk_en && sel_wr)
			sel_r <= sel_val;
	end

	logic dev_sel;
	assign dev_sel = ~sel_r[SEL_TYPE_BIT];

	// device status word; no serial path writes it
	logic [STAT_W-1:0] dev_word;
	always_comb begin
		dev_word = WORD_RESET;
		dev_word[BIT_HEADING   +: NUM_GAUGES] = heading;
		dev_word[BIT_ZERO_SIDE +: NUM_GAUGES] = zero_end_side;
		dev_word[BIT_MISMATCH  +: NUM_GAUGES] = target_mismatch;
		dev_word[BIT_SUP_HIGH]                = fl.sup_high;
		dev_word[BIT_SUP_LOW]                 = fl.sup_low;
		dev_word[BIT_CAL]                     = cal_out_of_range;
		dev_word[BIT_FAULT_ANY]               = fl.fault_any;
		dev_word[BIT_MOVED     +: NUM_GAUGES] = fl.moved;
		dev_word[BIT_HOMING    +: NUM_GAUGES] = fl.homing;
		dev_word[BIT_THERMAL   +: NUM_GAUGES] = fl.thermal;
	end

	// frame state machine
	gdsr_frame_t       st_r;
	logic [STAT_W-1:0] sh_r;
	logic [BITCNT_W-1:0] cnt_r;
	logic              any_bit_r;
	logic              si_cap_r;
	logic              dev_loaded_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_r <= GDSR_IDLE;
		end else if (clk_en) begin
			unique case (st_r)
				GDSR_IDLE:  if (cs_fall) st_r <= GDSR_SHIFT;
				GDSR_SHIFT: if (cs_rise) st_r <= GDSR_CHECK;
				GDSR_CHECK: st_r <= GDSR_IDLE;
			endcase
		end
	end

	// bit counter: synchronised rising sclk edges of the current frame
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_r     <= BITCNT_RESET;
			any_bit_r <= 1'b0;
		end else if (clk_en) begin
			if (st_r == GDSR_IDLE && cs_fall) begin
				cnt_r     <= BITCNT_RESET;
				any_bit_r <= 1'b0;
			end else if (st_r == GDSR_SHIFT && sclk_rise) begin
				cnt_r     <= cnt_r + 4'h1;
				any_bit_r <= 1'b1;
			end
		end
	end

	// si is taken at the rising sclk edge and entered at the falling one;
	// sampling at the fall would race the host moving si on that same edge
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			si_cap_r <= 1'b0;
		end else if (clk_en && st_r == GDSR_SHIFT && sclk_rise) begin
			si_cap_r <= si_q;
		end
	end

	// shift register: after 16 bits, received bits follow for daisy chaining
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sh_r         <= WORD_RESET;
			dev_loaded_r <= 1'b0;
		end else if (clk_en) begin
			if (st_r == GDSR_IDLE && cs_fall) begin
				sh_r         <= dev_sel ? dev_word : alt_status;
				dev_loaded_r <= dev_sel;
			end else if (st_r == GDSR_SHIFT && sclk_fall && any_bit_r) begin
				sh_r <= {sh_r[STAT_W-2:0], si_cap_r};
			end
		end
	end

	// length check at frame end; only a valid device-status read clears supply faults
	// the 4-bit count wraps to zero on any multiple of 16; any_bit_r rules out empty frames
	logic valid_len;
	assign valid_len = any_bit_r && (cnt_r == BITCNT_RESET);
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fl.clear_on_read <= 1'b0;
			fl.msg_end       <= 1'b0;
			msg_valid        <= 1'b0;
		end else if (clk_en) begin
			fl.clear_on_read <= (st_r == GDSR_SHIFT) && cs_rise && valid_len && dev_loaded_r;
			fl.msg_end       <= (st_r == GDSR_SHIFT) && cs_rise && valid_len;
			msg_valid        <= (st_r == GDSR_SHIFT) && cs_rise && valid_len;
		end
	end

	// so moves two cycles after the synchronised fall, so the host needs half periods of 4 cycles
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			so_out  <= 1'b0;
			so_oe_n <= 1'b1;
		end else if (clk_en) begin
			so_out  <= sh_r[STAT_W-1];
			so_oe_n <= ~(st_r == GDSR_SHIFT);
		end
	end

	// supply-high trips both drivers; thermal trips its own gauge
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			driver_off <= '0;
		else if (clk_en)
			driver_off <= {NUM_GAUGES{fl.sup_high}} | fl.thermal;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			status_select_field <= SEL_RESET;
		else if (clk_en)
			status_select_field <= sel_r;
	end
endmodule

// ### sim/gdsr_status_monitor.sv
// checker: port-level timing of the status report block
module gdsr_status_monitor
	import gdsr_pkg::*;
(
	input wire logic                  core_clk,            // clock
	input wire logic                  rst_n,               // sync reset
	input wire logic                  cs_n_pin,            // chip select
	input wire logic                  so_oe_n,             // out enable
	input wire logic                  sel_wr,              // select write
	input wire logic [SEL_W-1:0]      sel_val,             // select value
	input wire logic                  sup_high_evt,        // supply high
	input wire logic [NUM_GAUGES-1:0] thermal_evt,         // over temp
	input wire logic [NUM_GAUGES-1:0] driver_off,          // drivers off
	input wire logic [SEL_W-1:0]      status_select_field, // active select
	input wire logic                  msg_valid            // valid end
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_sel_load: assert property (sel_wr |-> ##2 status_select_field == $past(sel_val, 2))
		else $error("select value not taken");
	a_sel_hold: assert property (!$past(sel_wr) |=> $stable(status_select_field))
		else $error("select changed without a write");
	a_ovr_off: assert property (sup_high_evt |-> ##[1:3] driver_off == 2'h3)
		else $error("supply high left drivers on");
	a_hot_off: assert property (thermal_evt[1] |-> ##[1:3] driver_off[1])
		else $error("thermal trip left gauge on");
	a_oe_idle: assert property (cs_n_pin [*8] |-> so_oe_n)
		else $error("output driven outside frame");
	a_oe_drive: assert property ($fell(cs_n_pin) |-> ##[2:6] !so_oe_n)
		else $error("output not driven after select");
	a_oe_release: assert property ($rose(cs_n_pin) |-> ##[2:6] so_oe_n)
		else $error("output not released");
	a_valid_pulse: assert property (msg_valid |=> !msg_valid)
		else $error("valid pulse too long");
	a_valid_idle: assert property (msg_valid |-> cs_n_pin && $past(cs_n_pin))
		else $error("valid inside a frame");
	c_valid: cover property (msg_valid);
	c_ovr: cover property (driver_off == 2'h3);
	c_alt: cover property (status_select_field[SEL_TYPE_BIT] && msg_valid);
endmodule

bind gdsr_status_report gdsr_status_monitor gdsr_status_monitor_i (.core_clk, .rst_n, .cs_n_pin, .so_oe_n,
	.sel_wr, .sel_val, .sup_high_evt, .thermal_evt, .driver_off, .status_select_field, .msg_valid);

// ### sim/gdsr_spi_host.sv
// host model: spi bus master running frames of any length
module gdsr_spi_host (
	input  wire logic core_clk, // clock
	output logic      cs_n,     // chip select
	output logic      sclk,     // serial clock
	output logic      si,       // data to device
	input  wire logic so,       // data from device
	input  wire logic valid     // valid message pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end
	// sclk idles low at cs fall; 4-cycle half period covers the pin synchronisers
	task automatic xfer(input int n, input logic [31:0] din, output logic [31:0] dout, output logic ok);
		ok = 1'b0;
		dout = '0;
		cs_n <= 1'b0;
		si <= din[31];
		din = din << 1;
		repeat (8) @(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			sclk <= 1'b1;
			repeat (4) @(posedge core_clk);
			dout = {dout[30:0], so};
			sclk <= 1'b0;
			si <= din[31];
			din = din << 1;
			repeat (4) @(posedge core_clk);
		end
		cs_n <= 1'b1;
		si <= ~si;
		repeat (10) begin
			@(posedge core_clk);
			if (valid === 1'b1) ok = 1'b1;
		end
	endtask
endmodule

// ### sim/gdsr_status_report_bench.sv
// bench: self-checking test of the status report block
module gdsr_status_report_bench
	import gdsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
	logic core_clk = 0, rst_n = 0, sel_wr = 0, sup_h = 0, sup_l = 0, cal = 0, ok;
	logic [3:0] sel_val = 0, cur = 0;
	logic [15:0] alt = 0;
	logic [1:0] hd = 0, zs = 0, tm = 0, ps = 0, hst = 0, hsp = 0, zf = 0, te = 0, re = 0;
	logic [1:0] m_mv = 0, m_hm = 0, m_pz = 0, m_th = 0, doff;
	logic m_sh = 0, m_sl = 0, cs_n, sclk, si, so, oe_n, msg_v;
	logic [3:0] sel_f;
	logic [31:0] rd;
	int num_errors = 0, n_tests = 0, seed = 32'h700b_639b;
	gdsr_status_report gdsr_status_report_i (.core_clk, .rst_n, .clk_en(1'b1), .cs_n_pin(cs_n),
		.sclk_pin(sclk), .si_pin(si), .so_out(so), .so_oe_n(oe_n), .sel_wr, .sel_val, .alt_status(alt),
		.heading(hd), .zero_end_side(zs), .target_mismatch(tm), .cal_out_of_range(cal),
		.sup_high_evt(sup_h), .sup_low_evt(sup_l), .pos_step(ps), .homing_start(hst), .homing_stop(hsp),
		.zero_found(zf), .thermal_evt(te), .gauge_reenable(re), .driver_off(doff),
		.status_select_field(sel_f), .msg_valid(msg_v));
	gdsr_spi_host gdsr_spi_host_i (.core_clk, .cs_n, .sclk, .si, .so, .valid(msg_v));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	function automatic logic [15:0] exp_word();
		return {hd, zs, tm, m_sh, m_sl, cal, m_sh | m_sl, m_mv, m_hm, m_th};
	endfunction
	task automatic give_verdict();
		$display("errors %0d of %0d checks", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tick();
		@(posedge core_clk);
		{sup_h, sup_l, sel_wr, ps, hst, hsp, zf, te, re} <= '0;
		repeat (4) @(posedge core_clk);
	endtask
	task automatic frame(input int n);
		logic [15:0] e;
		logic [31:0] d;
		e = cur[SEL_TYPE_BIT] ? alt : exp_word();
		d = $random(seed);
		gdsr_spi_host_i.xfer(n, d, rd, ok);
		`CHK(ok, logic'(n % 16 == 0))
		if (n >= 16) `CHK(rd[n-1 -: 16], e)
		if (n == 32) `CHK(rd[15:0], d[31:16])
		if (ok) begin
			m_mv = 2'h0;
			m_hm = m_hm & ~m_pz;
			m_pz = 2'h0;
			if (!cur[SEL_TYPE_BIT]) {m_sh, m_sl} = 2'h0;
		end
	endtask
	task automatic sel(input logic [3:0] v);
		sel_val <= v;
		sel_wr <= 1'b1;
		cur = v;
		{hd, zs, tm, cal} <= 7'($random(seed));
		alt <= 16'($random(seed));
		tick();
		`CHK(sel_f, v)
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		`CHK({sel_f, doff, oe_n}, 7'h01)
		for (int i = 0; i < 16; i++) begin
			sel(4'(i));
			frame(16);
			frame(16);
		end
		sel(4'h7);
		sup_h <= 1'b1;
		m_sh = 1'b1;
		tick();
		`CHK(doff, 2'h3)
		frame(16);
		`CHK(doff, 2'h0)
		re <= 2'h3;
		hst <= 2'h3;
		m_hm = 2'h3;
		tick();
		frame(16);
		sup_l <= 1'b1;
		m_sl = 1'b1;
		tick();
		`CHK(doff, 2'h0)
		sel(4'hc);
		frame(16);
		sel(4'h3);
		frame(8);
		frame(20);
		frame(32);
		zf <= 2'h1;
		m_pz = 2'h1;
		ps <= 2'h2;
		m_mv = 2'h2;
		tick();
		frame(16);
		frame(16);
		hsp <= 2'h2;
		m_hm[1] = 1'b0;
		tick();
		frame(16);
		te <= 2'h2;
		m_th = 2'h2;
		tick();
		`CHK(doff, 2'h2)
		frame(16);
		re <= 2'h2;
		m_th = 2'h0;
		tick();
		`CHK(doff, 2'h0)
		frame(16);
		give_verdict();
	end
	initial begin
		repeat (40000) @(posedge core_clk);
		num_errors++;
		give_verdict();
	end
endmodule
